/* rtl/priv_issue_regs.svh */
// Purpose: Named constants for the privileged issue control block
// Assumes: Included by the stack and issue control modules, not by the package
// Notes: Definitions only
`ifndef PRIV_ISSUE_REGS_SVH
`define PRIV_ISSUE_REGS_SVH
`define FPC_LATENCY_CYC 3'h4
`define FETCH_WINDOW_LEN 3'h4
`define SPACE_SCORE_HI 7
`define SPACE_SCORE_LO 4
`define RS_DEPTH 8
`define PM_BIT 0
`endif

/* rtl/priv_issue_pkg.sv */
// Purpose: Types for the privileged issue control block
// Assumes: Header holds the numeric constants
// Notes: Operation classes presented at issue and retire
package priv_issue_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_LOAD, OP_STORE, OP_LOAD_U, OP_STORE_U,
        OP_PRIV_LOAD, OP_PRIV_STORE, OP_EVICT, OP_WHINT,
        OP_LOAD_LOCKED, OP_STORE_COND, OP_PRIV_STORE_COND
    } mem_op_e;
    typedef enum logic [1:0] {
        FL_IDLE, FL_ARMED, FL_DRAIN
    } flush_state_e;
endpackage : priv_issue_pkg

/* rtl/ret_stack_if.sv */
// Purpose: Carrier between issue control and the return stack
// Assumes: One clock domain
// Notes: Push and pop are one-cycle pulses
`timescale 1ns/1ps
interface ret_stack_if #(parameter int AW = 64);
    logic push;
    logic pop;
    logic [AW-1:0] push_addr;
    logic [AW-1:0] top_addr;
    logic top_valid;
    modport ctl (output push, output pop, output push_addr,
                 input top_addr, input top_valid);
    modport stk (input push, input pop, input push_addr,
                 output top_addr, output top_valid);
endinterface : ret_stack_if

/* rtl/ret_addr_stack.sv */
// Purpose: Return-address stack memory with registered read data
// Assumes: Push and pop not asserted together
// Notes: Wraps on overflow
`timescale 1ns/1ps
`include "priv_issue_regs.svh"
module ret_addr_stack #(
    parameter int DEPTH = `RS_DEPTH
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Stack port
    ret_stack_if.stk rs
);
    localparam int PW = $clog2(DEPTH);
    logic [$bits(rs.push_addr)-1:0] mem [DEPTH];
    logic [PW-1:0] ptr_reg;
    logic [PW:0] cnt_reg;
    logic [$bits(rs.push_addr)-1:0] top_reg;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (rs.push) begin
            ptr_reg <= ptr_reg + 1'b1;
            if (cnt_reg != (PW+1)'(DEPTH)) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end else if (rs.pop && cnt_reg != '0) begin
            ptr_reg <= ptr_reg - 1'b1;
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (rs.push) begin
            mem[ptr_reg] <= rs.push_addr;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (rs.push) begin
            top_reg <= rs.push_addr;
        end else begin
            top_reg <= mem[ptr_reg - PW'(rs.pop ? 2 : 1)];
        end
    end

    assign rs.top_addr = top_reg;
    assign rs.top_valid = (cnt_reg != '0);
endmodule : ret_addr_stack

/* rtl/priv_issue_ctl.sv */
// Purpose: Issue, retire and prediction control in privileged mode
// Assumes: Issue and retire events arrive as one-cycle pulses
// Notes: Firmware keeps its own ordering obligations
//
// Behaviour
// - On bad fetch address, fault register holds address bits 63:1.
// - Float control updates on retire; stalling return gives four cycles.
// - Cache disabled: fetch only by stream hits, wrap fill walks page.
// - Privileged store-conditional leaves lock flag as it was.
// - Ordinary memory operation between lock and store-conditional fails it, except OP_LOAD_U with i_mem_rd_zero.
// - Cache flush waits for stalling return and fetch drain.
// - Stalling return for clear-map write triggers no flush.
// - Mispredicted return may drop privileged mode temporarily.
// - Branches predicted not taken except first four-instruction fetch.
// - Register reads and writes wait on store bubbles; loads on load.
// - Non-privileged loads update fault registers; privileged never status.
`timescale 1ns/1ps
`include "priv_issue_regs.svh"
module priv_issue_ctl
    import priv_issue_pkg::*;
#(
    parameter int AW = 64,
    parameter int DW = 64
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Returns and prediction
    input wire logic i_ret_fetch,
    input wire logic i_ret_stall,
    input wire logic i_ret_mispred,
    input wire logic i_ret_native,
    input wire logic i_ret_retire,
    input wire logic i_trap_enter,
    input wire logic [AW-1:0] i_trap_pc,
    input wire logic i_call_entry,
    input wire logic i_flow_start,
    input wire logic i_fetch_slot,
    input wire logic i_cond_branch,
    input wire logic i_hint_taken,
    output logic o_predict_taken,
    output logic [AW-1:0] o_ret_predict,
    output logic o_ret_predict_valid,
    output logic o_priv_mode,
    // Jump fault
    input wire logic i_jump_fault,
    input wire logic [AW-1:0] i_fault_pc,
    output logic o_bad_fetch_address_flag,
    output logic [AW-1:0] o_fault_addr,
    output logic [AW-1:0] o_exception_pc,
    // Register reads, writes and loads
    input wire logic i_irw_retire,
    input wire logic i_irw_is_xlate,
    input wire logic i_irw_is_space,
    input wire logic [7:0] i_issue_scoreboard,
    input wire logic i_irw_req,
    input wire logic i_irr_req,
    input wire logic i_store_bubble_busy,
    input wire logic i_load_bubble_busy,
    input wire logic i_load_req,
    output logic o_irw_issue_ok,
    output logic o_irr_issue_ok,
    output logic o_load_issue_ok,
    output logic o_space_score_busy,
    // Float control
    input wire logic i_fpc_write_retire,
    input wire logic [DW-1:0] i_fpc_data,
    output logic [DW-1:0] o_float_control,
    output logic o_float_op_ok,
    // Instruction cache
    input wire logic i_icache_enable,
    input wire logic i_stream_hit,
    input wire logic i_wrap_fill,
    input wire logic i_flush_req,
    input wire logic i_clear_map_req,
    input wire logic i_fetch_outstanding,
    output logic o_fetch_supply_ok,
    output logic o_stream_page_walk,
    output logic o_icache_flush,
    // Lock flag and memory status
    input wire logic i_mem_valid,
    input wire logic [3:0] i_mem_op,
    input wire logic i_mem_rd_zero,
    input wire logic [AW-1:0] i_mem_addr,
    input wire logic i_mem_fault,
    output logic o_lock_flag,
    output logic o_sc_success,
    output logic o_sc_done,
    output logic o_mm_status_upd
);
    // ---------------------------------------------------------------
    // Return stack and privileged mode
    // ---------------------------------------------------------------
    ret_stack_if #(.AW(AW)) rs ();
    ret_addr_stack #(.DEPTH(`RS_DEPTH)) u_stack (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .rs(rs)
    );
    assign rs.push = i_trap_enter;
    assign rs.push_addr = i_trap_pc;
    assign rs.pop = i_ret_fetch && i_ret_native;
    assign o_ret_predict = rs.top_addr;
    assign o_ret_predict_valid = rs.top_valid && i_ret_native;

    logic priv_reg;
    logic spec_exit_reg;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            priv_reg <= 1'b1;
            spec_exit_reg <= 1'b0;
        end else if (i_trap_enter) begin
            priv_reg <= 1'b1;
            spec_exit_reg <= 1'b0;
        end else if (i_ret_retire) begin
            priv_reg <= 1'b0;
            spec_exit_reg <= 1'b0;
        end else if (i_ret_fetch && i_ret_mispred) begin
            spec_exit_reg <= 1'b1;
        end else if (spec_exit_reg && !i_ret_fetch) begin
            spec_exit_reg <= 1'b0;
        end
    end
    assign o_priv_mode = priv_reg && !spec_exit_reg;

    // ---------------------------------------------------------------
    // Branch prediction window
    // ---------------------------------------------------------------
    logic [2:0] win_reg;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            win_reg <= '0;
        end else if (i_flow_start && !i_call_entry) begin
            win_reg <= `FETCH_WINDOW_LEN;
        end else if (i_fetch_slot && win_reg != '0) begin
            win_reg <= win_reg - 1'b1;
        end
    end
    // Outside the first fetch, privileged branches go not taken
    assign o_predict_taken = i_cond_branch &&
        (!priv_reg || win_reg != '0) && i_hint_taken;

    // ---------------------------------------------------------------
    // Jump fault addressing
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bad_fetch_address_flag <= 1'b0;
            o_fault_addr <= '0;
            o_exception_pc <= '0;
        end else if (i_jump_fault) begin
            o_bad_fetch_address_flag <= 1'b1;
            o_fault_addr <= {i_fault_pc[AW-1:1], 1'b0};
            o_exception_pc <= {{(AW-1){1'b0}}, priv_reg};
        end else if (i_trap_enter) begin
            o_bad_fetch_address_flag <= 1'b0;
            o_exception_pc <= {i_trap_pc[AW-1:1], priv_reg};
        end
    end

    // ---------------------------------------------------------------
    // Issue gating
    // ---------------------------------------------------------------
    assign o_space_score_busy =
        |i_issue_scoreboard[`SPACE_SCORE_HI:`SPACE_SCORE_LO];
    assign o_irw_issue_ok = i_irw_req && !i_store_bubble_busy &&
        !(i_irw_is_space && o_space_score_busy);
    assign o_irr_issue_ok = i_irr_req && !i_store_bubble_busy;
    assign o_load_issue_ok = i_load_req && !i_load_bubble_busy;

    // ---------------------------------------------------------------
    // Float control update
    // ---------------------------------------------------------------
    logic [2:0] fpc_cnt_reg;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_float_control <= '0;
        end else if (i_fpc_write_retire) begin
            o_float_control <= i_fpc_data;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            fpc_cnt_reg <= '0;
        end else if (i_fpc_write_retire) begin
            fpc_cnt_reg <= `FPC_LATENCY_CYC;
        end else if (fpc_cnt_reg != '0) begin
            fpc_cnt_reg <= fpc_cnt_reg - 1'b1;
        end
    end
    assign o_float_op_ok = (fpc_cnt_reg == '0);

    // ---------------------------------------------------------------
    // Instruction fetch supply
    // ---------------------------------------------------------------
    assign o_fetch_supply_ok = i_icache_enable || i_stream_hit;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stream_page_walk <= 1'b0;
        end else if (i_icache_enable || i_stream_hit) begin
            o_stream_page_walk <= 1'b0;
        end else if (i_wrap_fill) begin
            o_stream_page_walk <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Instruction cache flush
    // ---------------------------------------------------------------
    flush_state_e fl_reg;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            fl_reg <= FL_IDLE;
        end else begin
            case (fl_reg)
                FL_IDLE: begin
                    if (i_flush_req) begin
                        fl_reg <= FL_ARMED;
                    end
                end
                FL_ARMED: begin
                    if (i_ret_retire && i_ret_stall) begin
                        fl_reg <= FL_DRAIN;
                    end
                end
                FL_DRAIN: begin
                    if (!i_fetch_outstanding) begin
                        fl_reg <= FL_IDLE;
                    end
                end
                default: fl_reg <= FL_IDLE;
            endcase
        end
    end
    // Clear-map requests never arm the flush machine
    logic unused_clear_map;
    assign unused_clear_map = i_clear_map_req;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_icache_flush <= 1'b0;
        end else begin
            o_icache_flush <= (fl_reg == FL_DRAIN) && !i_fetch_outstanding;
        end
    end

    // ---------------------------------------------------------------
    // Lock flag and memory status
    // ---------------------------------------------------------------
    logic [AW-1:0] lock_addr_reg;
    mem_op_e op;
    logic kills_lock;
    assign op = mem_op_e'(i_mem_op);
    assign kills_lock = i_mem_valid && (op == OP_LOAD ||
        op == OP_STORE || op == OP_STORE_U ||
        (op == OP_LOAD_U && !i_mem_rd_zero));
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_lock_flag <= 1'b0;
            lock_addr_reg <= '0;
        end else if (i_mem_valid && op == OP_LOAD_LOCKED) begin
            o_lock_flag <= 1'b1;
            lock_addr_reg <= i_mem_addr;
        end else if (kills_lock) begin
            o_lock_flag <= 1'b0;
        end else if (i_mem_valid && op == OP_STORE_COND) begin
            o_lock_flag <= 1'b0;
        end
        // Privileged store-conditional keeps the flag
    end
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sc_success <= 1'b0;
            o_sc_done <= 1'b0;
        end else begin
            o_sc_done <= i_mem_valid &&
                (op == OP_STORE_COND || op == OP_PRIV_STORE_COND);
            o_sc_success <= o_lock_flag &&
                lock_addr_reg == i_mem_addr;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mm_status_upd <= 1'b0;
        end else begin
            o_mm_status_upd <= i_mem_valid && i_mem_fault &&
                op != OP_PRIV_LOAD;
        end
    end
endmodule : priv_issue_ctl

/* verification/priv_issue_ctl_props.sv */
// Purpose: Port assertions for privileged issue control
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every instance of the design
`timescale 1ns/1ps
module priv_issue_ctl_props
    import priv_issue_pkg::*;
#(
    parameter int AW = 64,
    parameter int DW = 64
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Watched ports
    input wire logic i_jump_fault,
    input wire logic [AW-1:0] i_fault_pc,
    input wire logic [AW-1:0] o_fault_addr,
    input wire logic i_fpc_write_retire,
    input wire logic [DW-1:0] i_fpc_data,
    input wire logic [DW-1:0] o_float_control,
    input wire logic o_float_op_ok,
    input wire logic i_icache_enable,
    input wire logic i_stream_hit,
    input wire logic o_fetch_supply_ok,
    input wire logic i_store_bubble_busy,
    input wire logic o_irw_issue_ok,
    input wire logic i_irw_is_space,
    input wire logic [7:0] i_issue_scoreboard,
    input wire logic o_space_score_busy,
    input wire logic o_icache_flush,
    input wire logic i_fetch_outstanding,
    input wire logic i_mem_valid,
    input wire logic [3:0] i_mem_op,
    input wire logic o_lock_flag,
    input wire logic o_mm_status_upd
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    fault_addr_a: assert property (
        i_jump_fault |=> o_fault_addr == ($past(i_fault_pc) & ~AW'(1)))
        else $error("fault address wrong");
    fpc_delay_a: assert property (
        i_fpc_write_retire |=> !o_float_op_ok [*4] ##1 o_float_op_ok)
        else $error("float control delay wrong");
    fpc_value_a: assert property (
        i_fpc_write_retire |=> o_float_control == $past(i_fpc_data))
        else $error("float control not loaded");
    supply_gate_a: assert property (
        !i_icache_enable && !i_stream_hit |-> !o_fetch_supply_ok)
        else $error("fetch supplied without stream hit");
    bubble_gate_a: assert property (
        i_store_bubble_busy |-> !o_irw_issue_ok)
        else $error("register write issued on busy bubble");
    space_refuse_a: assert property (
        i_irw_is_space && i_issue_scoreboard[7:4] != 4'h0
        |-> !o_irw_issue_ok && o_space_score_busy)
        else $error("space write not held back");
    flush_drain_a: assert property (
        o_icache_flush |-> !$past(i_fetch_outstanding) ##1 !o_icache_flush)
        else $error("flush before fetch drain");
    priv_lock_a: assert property (
        i_mem_valid && i_mem_op == OP_PRIV_STORE_COND
        |=> o_lock_flag == $past(o_lock_flag))
        else $error("lock flag changed");
    mm_priv_a: assert property (
        i_mem_valid && i_mem_op == OP_PRIV_LOAD |=> !o_mm_status_upd)
        else $error("status updated by privileged load");
    cover property (i_fpc_write_retire);
    cover property (o_icache_flush);
    cover property (i_mem_valid && i_mem_op == OP_PRIV_STORE_COND);
endmodule : priv_issue_ctl_props
bind priv_issue_ctl priv_issue_ctl_props #(.AW(AW), .DW(DW)) i_props (.*);

/* verification/fw_stream_model.sv */
// Purpose: Firmware stream model for flush and clear-map writes
// Assumes: Start pulse from the bench, one clock
// Notes: Return follows the write after a separating gap
`timescale 1ns/1ps
module fw_stream_model (
    // Clock and control
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic i_map,
    // Firmware events
    output logic o_flush,
    output logic o_map,
    output logic o_ret,
    output logic o_outst
);
    initial begin
        {o_flush, o_map, o_ret, o_outst} = '0;
    end
    always begin
        do @(posedge i_clk_sys); while (!i_go);
        o_flush <= !i_map;
        o_map <= i_map;
        o_outst <= 1'b1;
        @(posedge i_clk_sys);
        o_flush <= 1'b0;
        o_map <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        o_ret <= 1'b1;
        @(posedge i_clk_sys);
        o_ret <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        o_outst <= 1'b0;
    end
endmodule : fw_stream_model

/* verification/privileged_mode_issue_control_tb.sv */
// Purpose: Self-checking bench for privileged issue control
// Assumes: Firmware model drives flush and return events
// Notes: Scenarios run in order from one initial block
`timescale 1ns/1ps
module privileged_mode_issue_control_tb;
    import priv_issue_pkg::*;
    logic i_clk_sys = 1'b0, i_nrst, ret, go, map;
    logic i_ret_fetch, i_ret_stall, i_ret_retire, i_flush_req;
    logic i_clear_map_req, i_fetch_outstanding, i_ret_mispred, i_ret_native;
    logic i_trap_enter, i_call_entry, i_flow_start, i_fetch_slot;
    logic i_cond_branch, i_hint_taken, i_jump_fault, i_irw_retire;
    logic i_irw_is_xlate, i_irw_is_space, i_irw_req, i_irr_req, i_load_req;
    logic i_store_bubble_busy, i_load_bubble_busy, i_fpc_write_retire;
    logic i_icache_enable, i_stream_hit, i_wrap_fill, i_mem_valid;
    logic i_mem_rd_zero, i_mem_fault;
    logic [3:0] i_mem_op;
    logic [7:0] i_issue_scoreboard;
    logic [63:0] i_trap_pc, i_fault_pc, i_fpc_data, i_mem_addr;
    logic o_predict_taken, o_ret_predict_valid, o_priv_mode, o_sc_done;
    logic o_bad_fetch_address_flag, o_irw_issue_ok, o_irr_issue_ok;
    logic o_load_issue_ok, o_space_score_busy, o_float_op_ok, o_lock_flag;
    logic o_fetch_supply_ok, o_stream_page_walk, o_icache_flush;
    logic o_sc_success, o_mm_status_upd;
    logic [63:0] o_ret_predict, o_fault_addr, o_exception_pc, o_float_control;
    int n_fail = 0, check_count = 0, cyc = 0, i;
    mem_op_e ops[8] = '{OP_LOAD, OP_STORE, OP_LOAD_U, OP_STORE_U,
        OP_PRIV_LOAD, OP_PRIV_STORE, OP_EVICT, OP_WHINT};
    always #20 i_clk_sys = ~i_clk_sys;
    assign i_ret_fetch = ret;
    assign i_ret_stall = ret;
    assign i_ret_retire = ret;
    priv_issue_ctl i_dut (.*);
    fw_stream_model i_fw (.i_clk_sys(i_clk_sys), .i_go(go), .i_map(map),
        .o_flush(i_flush_req), .o_map(i_clear_map_req), .o_ret(ret),
        .o_outst(i_fetch_outstanding));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic tick();
        @(posedge i_clk_sys);
    endtask : tick
    task automatic sample();
        @(posedge i_clk_sys);
        #1;
    endtask : sample
    task automatic mem(input mem_op_e op, input logic [63:0] a);
        tick();
        i_mem_valid <= 1'b1;
        i_mem_op <= op;
        i_mem_addr <= a;
        tick();
        i_mem_valid <= 1'b0;
        #1;
    endtask : mem
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fault();
        tick();
        i_jump_fault <= 1'b1;
        i_trap_enter <= 1'b1;
        i_ret_native <= 1'b1;
        i_fault_pc <= 64'hFFFF_0000_1234_5677;
        i_trap_pc <= 64'h0000_0000_0000_4000;
        tick();
        i_jump_fault <= 1'b0;
        i_trap_enter <= 1'b0;
        #1;
        check(o_bad_fetch_address_flag, 1'b1);
        check(o_fault_addr, 64'hFFFF_0000_1234_5676);
        check(o_exception_pc[0], 1'b1);
        check(o_ret_predict, 64'h0000_0000_0000_4000);
        check(o_ret_predict_valid, 1'b1);
        check(o_priv_mode, 1'b1);
        $display("test fault done");
    endtask : t_fault
    task automatic t_fpc();
        tick();
        i_fpc_write_retire <= 1'b1;
        i_fpc_data <= 64'h0123_4567_89AB_CDEF;
        tick();
        i_fpc_write_retire <= 1'b0;
        #1;
        check(o_float_control, 64'h0123_4567_89AB_CDEF);
        for (i = 0; i < 4; i++) begin
            check(o_float_op_ok, 1'b0);
            sample();
        end
        check(o_float_op_ok, 1'b1);
        $display("test float control done");
    endtask : t_fpc
    task automatic t_issue();
        tick();
        {i_store_bubble_busy, i_irw_req, i_irr_req, i_load_req} <= 4'hF;
        #1;
        check(o_irw_issue_ok, 1'b0);
        check(o_irr_issue_ok, 1'b0);
        check(o_load_issue_ok, 1'b1);
        tick();
        i_store_bubble_busy <= 1'b0;
        i_load_bubble_busy <= 1'b1;
        #1;
        check(o_load_issue_ok, 1'b0);
        check(o_irw_issue_ok, 1'b1);
        for (i = 4; i < 8; i++) begin
            tick();
            i_irw_is_space <= 1'b1;
            i_issue_scoreboard <= 8'h01 << i;
            #1;
            check(o_irw_issue_ok, 1'b0);
            check(o_space_score_busy, 1'b1);
        end
        tick();
        i_issue_scoreboard <= 8'h0F;
        {i_irw_retire, i_irw_is_xlate} <= 2'h3;
        #1;
        check(o_irw_issue_ok, 1'b1);
        check(o_space_score_busy, 1'b0);
        tick();
        {i_irw_req, i_irr_req, i_load_req, i_load_bubble_busy} <= 4'h0;
        {i_irw_is_space, i_irw_retire, i_irw_is_xlate} <= 3'h0;
        i_issue_scoreboard <= 8'h00;
        $display("test issue done");
    endtask : t_issue
    task automatic t_supply();
        tick();
        i_wrap_fill <= 1'b1;
        sample();
        check(o_fetch_supply_ok, 1'b0);
        check(o_stream_page_walk, 1'b1);
        tick();
        i_stream_hit <= 1'b1;
        i_wrap_fill <= 1'b0;
        #1;
        check(o_fetch_supply_ok, 1'b1);
        sample();
        check(o_stream_page_walk, 1'b0);
        tick();
        i_stream_hit <= 1'b0;
        i_icache_enable <= 1'b1;
        #1;
        check(o_fetch_supply_ok, 1'b1);
        $display("test supply done");
    endtask : t_supply
    task automatic t_pred();
        tick();
        i_flow_start <= 1'b1;
        tick();
        i_flow_start <= 1'b0;
        {i_cond_branch, i_hint_taken} <= 2'h3;
        #1;
        check(o_predict_taken, 1'b1);
        tick();
        i_fetch_slot <= 1'b1;
        repeat (4) tick();
        i_fetch_slot <= 1'b0;
        #1;
        check(o_predict_taken, 1'b0);
        tick();
        {i_call_entry, i_flow_start} <= 2'h3;
        tick();
        {i_call_entry, i_flow_start} <= 2'h0;
        #1;
        check(o_predict_taken, 1'b0);
        tick();
        {i_cond_branch, i_hint_taken} <= 2'h0;
        $display("test predict done");
    endtask : t_pred
    task automatic t_lock();
        mem(OP_LOAD, 64'h100);
        for (i = 0; i < 8; i++) begin
            mem(OP_LOAD_LOCKED, 64'h200);
            mem(ops[i], 64'h300);
            mem(OP_STORE_COND, 64'h200);
            check(o_sc_done, 1'b1);
            check(o_sc_success, i > 3);
        end
        mem(OP_LOAD_LOCKED, 64'h200);
        mem(OP_PRIV_STORE_COND, 64'h200);
        check(o_lock_flag, 1'b1);
        mem(OP_STORE_COND, 64'h200);
        check(o_sc_success, 1'b1);
        tick();
        i_mem_fault <= 1'b1;
        mem(OP_PRIV_LOAD, 64'h400);
        check(o_mm_status_upd, 1'b0);
        mem(OP_LOAD, 64'h400);
        check(o_mm_status_upd, 1'b1);
        tick();
        i_mem_fault <= 1'b0;
        $display("test lock done");
    endtask : t_lock
    task automatic t_flush(input logic m);
        int n;
        tick();
        go <= 1'b1;
        map <= m;
        tick();
        go <= 1'b0;
        for (n = 0; n < 30 && o_icache_flush !== 1'b1; n++) sample();
        check(o_icache_flush, !m);
        check(i_fetch_outstanding, 1'b0);
        sample();
        check(o_icache_flush, 1'b0);
        check(o_priv_mode, 1'b0);
        check(o_ret_predict_valid, 1'b0);
        $display("test flush done");
    endtask : t_flush
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {go, map, i_ret_mispred, i_ret_native, i_trap_enter, i_call_entry,
            i_flow_start, i_fetch_slot, i_cond_branch, i_hint_taken,
            i_jump_fault, i_irw_retire, i_irw_is_xlate, i_irw_is_space,
            i_irw_req, i_irr_req, i_load_req, i_store_bubble_busy,
            i_load_bubble_busy, i_fpc_write_retire, i_icache_enable,
            i_stream_hit, i_wrap_fill, i_mem_valid, i_mem_rd_zero,
            i_mem_fault, i_mem_op, i_issue_scoreboard, i_trap_pc,
            i_fault_pc, i_fpc_data, i_mem_addr} = '0;
        i_nrst = 1'b0;
        repeat (3) tick();
        i_nrst <= 1'b1;
        t_fault();
        t_fpc();
        t_issue();
        t_supply();
        t_pred();
        t_lock();
        t_flush(1'b0);
        t_flush(1'b1);
        conclude();
    end
endmodule : privileged_mode_issue_control_tb
